// *** ccdvp_regs.sv ***
// Function
// - outputs 13-24 each pick a group, 2 bits
// - each group picks one of 32 banks
// - advance bit steps sequence at next line
// - restart bit reloads the region sequence number
// - group a start and length in one word
// - group a has four line-rotation repeat counts
// - groups b, c, d own start and length
// - groups b, c, d odd and even repeats
// - hold positions freeze vertical outputs
// - release positions let held patterns finish
// - blanking start and end positions
// - blanking length repeated by 8-bit count
// - odd hclocks masked to their polarity bit
// - even hclocks masked to their polarity bit
// - last-stage hclock masked to its bit
// - third-phase hclock masked in three-phase mode
// - odd-line toggles, ignored in mode 1
// - mode 0 toggles shape blanking, mode 1 not
// - hold acts only on enabled groups, per parity
`timescale 1ns/1ps
`include "ccdvp_consts.svh"
module ccdvp_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic field_boundary_update,
  input wire logic line_start,
  input wire logic line_odd,
  input wire logic [1:0] line_index,
  input wire logic [12:0] hcount,
  input wire logic [4:0] region_sequence,
  input wire logic [3:0] group_level,
  input wire logic odd_hclock_in,
  input wire logic even_hclock_in,
  input wire logic last_stage_hclock_in,
  input wire logic third_phase_hclock_in,
  input wire logic three_phase_enable,
  output logic [11:0] upper_vout,
  output logic [19:0] vertical_pattern_bank,
  output logic [4:0] sequence_number,
  output logic [3:0] group_active,
  output logic [3:0] group_frozen,
  output logic horizontal_blanking,
  output logic odd_hclock,
  output logic even_hclock,
  output logic last_stage_hclock,
  output logic third_phase_hclock
);
  logic [`CCDVP_REG_W-1:0] shadow [0:`CCDVP_SLOTS-1];
  logic [`CCDVP_REG_W-1:0] live [0:`CCDVP_SLOTS-1];
  logic [`CCDVP_HOLD_EN_W-1:0] shadow_hold_en;
  logic [`CCDVP_HOLD_EN_W-1:0] live_hold_en;
  logic [1:0] shadow_mode;
  logic [1:0] live_mode;
  logic field_sync;
  logic field_sync_d;
  ccdvp_pkg::ccdvp_blk_state_t blk_state;
  ccdvp_pkg::ccdvp_blk_state_t next_blk_state;
  logic [12:0] blk_cnt;
  logic [7:0] blk_reps;
  logic toggle_level;
  logic [3:0] group_active_w;

  // bus decode
  wire [9:0] idx = paddr[11:2];
  wire in_table = (idx >= `CCDVP_IDX_GROUP_MAP) && (idx <= `CCDVP_IDX_ODD_TOGGLE);
  wire [4:0] slot = 5'(idx - `CCDVP_IDX_GROUP_MAP);
  wire is_hold_en = (idx == `CCDVP_IDX_HOLD_ENABLE);
  wire is_mode = (idx == `CCDVP_IDX_BLK_MODE);
  wire is_status = (idx == `CCDVP_IDX_STATUS);
  wire mapped = in_table || is_hold_en || is_mode || is_status;
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire bad_access = !mapped || (pwrite && is_status);
  wire wr_en = access && pwrite && !bad_access;
  wire [`CCDVP_REG_W-1:0] slot_mask =
    (idx == `CCDVP_IDX_GROUP_MAP) ? `CCDVP_MASK_24 :
    (idx == `CCDVP_IDX_BANK_SEQ) ? `CCDVP_MASK_22 :
    (idx == `CCDVP_IDX_BLK_LEN_REP) ? `CCDVP_MASK_25 : `CCDVP_MASK_26;
  wire [31:0] status_word = {21'h000000, group_frozen, horizontal_blanking, line_odd,
    sequence_number};
  wire [31:0] table_word = in_table ? {6'h00, shadow[slot]} : 32'h00000000;
  wire [31:0] rd_word =
    in_table ? table_word :
    is_hold_en ? {11'h000, shadow_hold_en} :
    is_mode ? {30'h00000000, shadow_mode} :
    is_status ? status_word : 32'h00000000;
  wire field_pulse = field_sync && !field_sync_d;

  assign pready = 1'b1;
  assign pslverr = access && bad_access;

  // apb read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
      prdata <= rd_word;
  end

  // software-visible shadow copies
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < `CCDVP_SLOTS; i++)
        shadow[i] <= `CCDVP_RESET_WORD;
      shadow_hold_en <= 21'h000000;
      shadow_mode <= `CCDVP_RESET_MODE;
    end
    else if (wr_en)
    begin
      if (in_table)
        shadow[slot] <= pwdata[`CCDVP_REG_W-1:0] & slot_mask;
      if (is_hold_en)
        shadow_hold_en <= pwdata[`CCDVP_HOLD_EN_W-1:0];
      if (is_mode)
        shadow_mode <= pwdata[1:0];
    end
  end

  // field boundary arrives from a pin
  ccdvp_sync2 u_field_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(field_boundary_update),
    .sync_out(field_sync)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      field_sync_d <= 1'b0;
    else
      field_sync_d <= field_sync;
  end

  // live copies load only at the boundary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < `CCDVP_SLOTS; i++)
        live[i] <= `CCDVP_RESET_WORD;
      live_hold_en <= 21'h000000;
      live_mode <= `CCDVP_RESET_MODE;
    end
    else if (field_pulse)
    begin
      for (int i = 0; i < `CCDVP_SLOTS; i++)
        live[i] <= shadow[i];
      live_hold_en <= shadow_hold_en;
      live_mode <= shadow_mode;
    end
  end

  // live field views
  wire [`CCDVP_REG_W-1:0] map_word = live[0];
  wire [`CCDVP_REG_W-1:0] bank_word = live[1];
  wire seq_advance = bank_word[`CCDVP_SEQ_ADV_BIT];
  wire seq_restart = bank_word[`CCDVP_SEQ_RST_BIT];
  wire [`CCDVP_REG_W-1:0] blk_pos_word = live[15];
  wire [`CCDVP_REG_W-1:0] blk_len_word = live[16];
  wire [`CCDVP_REG_W-1:0] toggle_word = live[17];
  wire [12:0] blk_start = blk_pos_word[`CCDVP_POS_LO +: `CCDVP_POS_W];
  wire [12:0] blk_end = blk_pos_word[`CCDVP_POS_HI +: `CCDVP_POS_W];
  wire [12:0] blk_len = blk_len_word[`CCDVP_POS_LO +: `CCDVP_POS_W];
  wire [7:0] blk_rep = blk_len_word[`CCDVP_BLK_REP_LSB +: `CCDVP_BLK_REP_W];
  wire [12:0] toggle_1 = toggle_word[`CCDVP_POS_LO +: `CCDVP_POS_W];
  wire [12:0] toggle_2 = toggle_word[`CCDVP_POS_HI +: `CCDVP_POS_W];
  wire normal_mode = (live_mode != ccdvp_pkg::CCDVP_MODE_REPEAT_AREA);
  wire [3:0] hold_enable = line_odd ? live_hold_en[`CCDVP_HOLD_ODD_LSB +: 4] :
    live_hold_en[`CCDVP_HOLD_EVEN_LSB +: 4];

  // bank selection per group
  assign vertical_pattern_bank = bank_word[19:0];

  // sequence number stepping
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sequence_number <= 5'h00;
    else if (line_start)
    begin
      if (seq_restart)
        sequence_number <= region_sequence;
      else if (seq_advance)
        sequence_number <= sequence_number + 5'h01;
    end
  end

  // hold windows, compared with the pixel counter
  logic [3:0] pair_hit;
  genvar p;
  generate
    for (p = 0; p < 4; p++)
    begin : g_hold
      wire [`CCDVP_REG_W-1:0] pair_word = live[11 + p];
      wire [12:0] hold_at = pair_word[`CCDVP_POS_LO +: `CCDVP_POS_W];
      wire [12:0] release_at = pair_word[`CCDVP_POS_HI +: `CCDVP_POS_W];
      assign pair_hit[p] = (hcount >= hold_at) && (hcount < release_at);
    end
  endgenerate

  wire hold_zone = |pair_hit;
  assign group_frozen = hold_enable & {4{hold_zone}};

  // per-group pattern timers
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_group
      wire [`CCDVP_REG_W-1:0] sl_word = (g == 0) ? live[2] : live[3 + 2 * g];
      wire [`CCDVP_REG_W-1:0] rep_a = line_index[1] ? live[4] : live[3];
      wire [12:0] rep_a_sel = line_index[0] ? rep_a[`CCDVP_POS_HI +: `CCDVP_POS_W] :
        rep_a[`CCDVP_POS_LO +: `CCDVP_POS_W];
      wire [`CCDVP_REG_W-1:0] rep_word = (g == 0) ? live[3] : live[4 + 2 * g];
      wire [12:0] rep_oe = line_odd ? rep_word[`CCDVP_POS_LO +: `CCDVP_POS_W] :
        rep_word[`CCDVP_POS_HI +: `CCDVP_POS_W];
      wire [12:0] rep_sel = (g == 0) ? rep_a_sel : rep_oe;
      ccdvp_group_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .line_start(line_start),
        .hcount(hcount),
        .start_pos(sl_word[`CCDVP_POS_LO +: `CCDVP_POS_W]),
        .length(sl_word[`CCDVP_POS_HI +: `CCDVP_POS_W]),
        .repeat_count(rep_sel),
        .frozen(group_frozen[g]),
        .active(group_active_w[g]),
        .position()
      );
    end
  endgenerate

  assign group_active = group_active_w;

  // upper vertical outputs follow their group unless held
  genvar v;
  generate
    for (v = 0; v < 12; v++)
    begin : g_vout
      wire [1:0] grp = map_word[2 * v +: 2];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          upper_vout[v] <= 1'b0;
        else if (!group_frozen[grp])
          upper_vout[v] <= group_level[grp];
      end
    end
  endgenerate

  // blanking burst sequencer
  wire [12:0] blk_last = (blk_len == 13'h0000) ? 13'h0000 : blk_len - 13'h0001;
  wire burst_end = (blk_cnt == blk_last);
  wire reps_done = (blk_reps >= blk_rep);

  always_comb
  begin
    next_blk_state = blk_state;
    case (blk_state)
      ccdvp_pkg::CCDVP_BLK_IDLE:
        if (hcount == blk_start)
          next_blk_state = ccdvp_pkg::CCDVP_BLK_RUN;
      ccdvp_pkg::CCDVP_BLK_RUN:
        if ((hcount == blk_end) || (burst_end && reps_done))
          next_blk_state = ccdvp_pkg::CCDVP_BLK_DONE;
      ccdvp_pkg::CCDVP_BLK_DONE:
        next_blk_state = ccdvp_pkg::CCDVP_BLK_DONE;
      default:
        next_blk_state = ccdvp_pkg::CCDVP_BLK_IDLE;
    endcase
    if (line_start)
      next_blk_state = ccdvp_pkg::CCDVP_BLK_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blk_state <= ccdvp_pkg::CCDVP_BLK_IDLE;
      blk_cnt <= 13'h0000;
      blk_reps <= 8'h00;
    end
    else
    begin
      blk_state <= next_blk_state;
      if (blk_state != ccdvp_pkg::CCDVP_BLK_RUN)
      begin
        blk_cnt <= 13'h0000;
        blk_reps <= 8'h00;
      end
      else if (burst_end)
      begin
        blk_cnt <= 13'h0000;
        blk_reps <= blk_reps + 8'h01;
      end
      else
        blk_cnt <= blk_cnt + 13'h0001;
    end
  end

  // odd-line toggles act only in normal mode
  wire toggle_hit = (hcount == toggle_1) || (hcount == toggle_2);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      toggle_level <= 1'b0;
    else if (line_start)
      toggle_level <= 1'b0;
    else if (normal_mode && line_odd && toggle_hit)
      toggle_level <= ~toggle_level;
  end

  wire blank_now = (blk_state == ccdvp_pkg::CCDVP_BLK_RUN) ^ toggle_level;

  // horizontal clock masking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      horizontal_blanking <= 1'b0;
      odd_hclock <= 1'b0;
      even_hclock <= 1'b0;
      last_stage_hclock <= 1'b0;
      third_phase_hclock <= 1'b0;
    end
    else
    begin
      horizontal_blanking <= blank_now;
      odd_hclock <= blank_now ? blk_len_word[`CCDVP_MASK_ODD_BIT] : odd_hclock_in;
      even_hclock <= blank_now ? blk_len_word[`CCDVP_MASK_EVEN_BIT] : even_hclock_in;
      last_stage_hclock <= blank_now ? blk_len_word[`CCDVP_MASK_LAST_BIT] : last_stage_hclock_in;
      third_phase_hclock <= (blank_now && three_phase_enable) ?
        blk_len_word[`CCDVP_MASK_THIRD_BIT] : third_phase_hclock_in;
    end
  end
endmodule : ccdvp_regs

// *** ccdvp_consts.svh ***
`ifndef CCDVP_CONSTS_SVH
`define CCDVP_CONSTS_SVH

// register indices, byte address is four times the index
`define CCDVP_IDX_GROUP_MAP 10'h008
`define CCDVP_IDX_BANK_SEQ 10'h009
`define CCDVP_IDX_A_START_LEN 10'h00a
`define CCDVP_IDX_A_REP_12 10'h00b
`define CCDVP_IDX_A_REP_34 10'h00c
`define CCDVP_IDX_B_START_LEN 10'h00d
`define CCDVP_IDX_B_REP 10'h00e
`define CCDVP_IDX_C_START_LEN 10'h00f
`define CCDVP_IDX_C_REP 10'h010
`define CCDVP_IDX_D_START_LEN 10'h011
`define CCDVP_IDX_D_REP 10'h012
`define CCDVP_IDX_HOLD_1 10'h013
`define CCDVP_IDX_HOLD_4 10'h016
`define CCDVP_IDX_BLK_START_END 10'h017
`define CCDVP_IDX_BLK_LEN_REP 10'h018
`define CCDVP_IDX_ODD_TOGGLE 10'h019
`define CCDVP_IDX_HOLD_ENABLE 10'h020
`define CCDVP_IDX_BLK_MODE 10'h030
`define CCDVP_IDX_STATUS 10'h031

// table slots and widths
`define CCDVP_SLOTS 18
`define CCDVP_REG_W 26
`define CCDVP_MASK_24 26'h0ffffff
`define CCDVP_MASK_22 26'h03fffff
`define CCDVP_MASK_25 26'h1ffffff
`define CCDVP_MASK_26 26'h3ffffff
`define CCDVP_HOLD_EN_W 21

// field positions
`define CCDVP_POS_LO 0
`define CCDVP_POS_HI 13
`define CCDVP_POS_W 13
`define CCDVP_BANK_W 5
`define CCDVP_SEQ_ADV_BIT 20
`define CCDVP_SEQ_RST_BIT 21
`define CCDVP_BLK_REP_LSB 13
`define CCDVP_BLK_REP_W 8
`define CCDVP_MASK_ODD_BIT 21
`define CCDVP_MASK_EVEN_BIT 22
`define CCDVP_MASK_LAST_BIT 23
`define CCDVP_MASK_THIRD_BIT 24
`define CCDVP_HOLD_EVEN_LSB 13
`define CCDVP_HOLD_ODD_LSB 17

// reset values
`define CCDVP_RESET_WORD 26'h0000000
`define CCDVP_RESET_MODE 2'h0

`endif

// *** ccdvp_pkg.sv ***
package ccdvp_pkg;

  typedef enum logic [1:0]
  {
    CCDVP_BLK_IDLE = 2'b00,
    CCDVP_BLK_RUN = 2'b01,
    CCDVP_BLK_DONE = 2'b11
  } ccdvp_blk_state_t;

  typedef enum logic [1:0]
  {
    CCDVP_MODE_NORMAL = 2'b00,
    CCDVP_MODE_REPEAT_AREA = 2'b01
  } ccdvp_blk_mode_t;

endpackage : ccdvp_pkg

// *** ccdvp_sync2.sv ***
`timescale 1ns/1ps
module ccdvp_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : ccdvp_sync2

// *** ccdvp_group_timer.sv ***
`timescale 1ns/1ps
module ccdvp_group_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic line_start,
  input wire logic [12:0] hcount,
  input wire logic [12:0] start_pos,
  input wire logic [12:0] length,
  input wire logic [12:0] repeat_count,
  input wire logic frozen,
  output logic active,
  output logic [12:0] position
);
  logic done;
  logic [12:0] reps;
  wire [12:0] last_pos = (length == 13'h0000) ? 13'h0000 : length - 13'h0001;
  wire begin_hit = !active && !done && (hcount == start_pos);
  wire last_rep = (reps >= repeat_count);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active <= 1'b0;
      done <= 1'b0;
      position <= 13'h0000;
      reps <= 13'h0000;
    end
    else if (line_start)
    begin
      active <= 1'b0;
      done <= 1'b0;
      position <= 13'h0000;
      reps <= 13'h0000;
    end
    else if (begin_hit)
    begin
      active <= 1'b1;
      position <= 13'h0000;
    end
    else if (active && !frozen)
    begin
      if (position == last_pos)
      begin
        position <= 13'h0000;
        if (last_rep)
        begin
          active <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          reps <= reps + 13'h0001;
        end
      end
      else
      begin
        position <= position + 13'h0001;
      end
    end
  end
endmodule : ccdvp_group_timer

// *** ccdvp_sensor_model.sv ***
`timescale 1ns/1ps
module ccdvp_sensor_model #(
  parameter int LINE_LEN = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic [12:0] hcount,
  output logic line_start,
  output logic line_odd,
  output logic [1:0] line_index,
  output logic odd_hclock_in,
  output logic even_hclock_in,
  output logic last_stage_hclock_in,
  output logic third_phase_hclock_in
);
  logic wrap;
  assign wrap = (hcount == 13'(LINE_LEN - 1));
  // raw clock phases taken from the pixel count
  assign odd_hclock_in = hcount[0];
  assign even_hclock_in = ~hcount[0];
  assign last_stage_hclock_in = hcount[0];
  assign third_phase_hclock_in = hcount[1];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hcount <= 13'h0;
      line_start <= 1'h0;
      line_odd <= 1'h0;
      line_index <= 2'h0;
    end
    else
    begin
      hcount <= wrap ? 13'h0 : hcount + 13'h1;
      line_start <= wrap;
      if (wrap)
      begin
        line_odd <= ~line_odd;
        line_index <= line_index + 2'h1;
      end
    end
  end
endmodule : ccdvp_sensor_model

// *** ccdvp_regs_chk.sv ***
`timescale 1ns/1ps
module ccdvp_regs_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic line_start,
  input wire logic field_boundary_update,
  input wire logic [19:0] vertical_pattern_bank,
  input wire logic odd_hclock_in,
  input wire logic even_hclock_in,
  input wire logic last_stage_hclock_in,
  input wire logic [4:0] sequence_number,
  input wire logic horizontal_blanking,
  input wire logic odd_hclock,
  input wire logic even_hclock,
  input wire logic last_stage_hclock
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable;
  a_ready_access: assert property (acc |-> pready) else $error("ready low");
  a_bank_on_load: assert property (!$stable(vertical_pattern_bank) |-> $past(field_boundary_update, 3))
    else $error("bank moved off boundary");
  a_unmapped_err: assert property (acc && paddr == 12'hffc |-> pslverr) else $error("no error");
  a_idle_no_err: assert property (!acc |-> !pslverr) else $error("stray error");
  a_err_read_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read data");
  a_seq_on_line: assert property (!$stable(sequence_number) |-> $past(line_start))
    else $error("sequence moved");
  a_odd_pass: assert property ($past(presetn) && !horizontal_blanking |-> odd_hclock == $past(odd_hclock_in))
    else $error("odd clock");
  a_even_pass: assert property ($past(presetn) && !horizontal_blanking |-> even_hclock == $past(even_hclock_in))
    else $error("even clock");
  a_last_pass: assert property ($past(presetn) && !horizontal_blanking
    |-> last_stage_hclock == $past(last_stage_hclock_in)) else $error("last clock");
  a_mask_steady: assert property (horizontal_blanking && $past(horizontal_blanking)
    |-> $stable(odd_hclock) && $stable(even_hclock)) else $error("mask moved");
  c_refused: cover property (acc && pslverr);
  c_blank: cover property (horizontal_blanking);
  c_seq: cover property (!$stable(sequence_number));
  c_bank_load: cover property (!$stable(vertical_pattern_bank));
endmodule : ccdvp_regs_chk
bind ccdvp_regs ccdvp_regs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .line_start, .field_boundary_update, .vertical_pattern_bank, .odd_hclock_in, .even_hclock_in,
  .last_stage_hclock_in, .sequence_number,
  .horizontal_blanking, .odd_hclock, .even_hclock, .last_stage_hclock);

// *** tb_ccd_vertical_pattern_and_hblank_regs.sv ***
`timescale 1ns/1ps
`include "ccdvp_consts.svh"
module tb_ccd_vertical_pattern_and_hblank_regs;
  logic pclk, presetn, psel, penable, pwrite, field_boundary_update, three_phase_enable;
  logic [11:0] paddr, upper_vout;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, e, line_start, line_odd, horizontal_blanking;
  logic odd_hclock_in, even_hclock_in, last_stage_hclock_in, third_phase_hclock_in;
  logic odd_hclock, even_hclock, last_stage_hclock, third_phase_hclock;
  logic [1:0] line_index;
  logic [12:0] hcount;
  logic [4:0] region_sequence, sequence_number, s;
  logic [3:0] group_level, group_active, group_frozen;
  logic [19:0] vertical_pattern_bank;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  ccdvp_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .field_boundary_update, .line_start, .line_odd, .line_index, .hcount, .region_sequence, .group_level,
    .odd_hclock_in, .even_hclock_in, .last_stage_hclock_in, .third_phase_hclock_in, .three_phase_enable,
    .upper_vout, .vertical_pattern_bank, .sequence_number, .group_active, .group_frozen,
    .horizontal_blanking, .odd_hclock, .even_hclock, .last_stage_hclock, .third_phase_hclock);
  ccdvp_sensor_model #(.LINE_LEN(64)) u_ccd (.pclk, .presetn, .hcount, .line_start, .line_odd,
    .line_index, .odd_hclock_in, .even_hclock_in, .last_stage_hclock_in, .third_phase_hclock_in);
  initial
  begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic sync_fields;
    @(posedge pclk);
    field_boundary_update <= 1'h1;
    repeat (3) @(posedge pclk);
    field_boundary_update <= 1'h0;
    repeat (6) @(posedge pclk);
  endtask : sync_fields
  task automatic at_pos(input logic [12:0] v, input logic odd);
    do
      @(posedge pclk);
    while (!(hcount === v && line_odd === odd));
  endtask : at_pos
  task automatic next_line;
    do
      @(posedge pclk);
    while (line_start !== 1'h1);
    repeat (2) @(posedge pclk);
  endtask : next_line
  task automatic t_regs;
    logic [11:0] a;
    int w;
    for (int i = 0; i < 18; i++)
    begin
      a = {`CCDVP_IDX_GROUP_MAP + 10'(i), 2'h0};
      w = (i == 0) ? 24 : (i == 1) ? 22 : (i == 16) ? 25 : 26;
      apb(1'h0, a, 32'h0);
      chk(q, 32'h0);
      apb(1'h1, a, 32'hffffffff);
      apb(1'h0, a, 32'h0);
      chk(q, 32'hffffffff >> (32 - w));
    end
  endtask : t_regs
  task automatic t_refuse;
    apb(1'h0, 12'hffc, 32'h0);
    chk(e, 1'h1);
    chk(q, 32'h0);
    apb(1'h1, {`CCDVP_IDX_STATUS, 2'h0}, 32'hffffffff);
    chk(e, 1'h1);
    apb(1'h0, {`CCDVP_IDX_STATUS, 2'h0}, 32'h0);
    chk(e, 1'h0);
  endtask : t_refuse
  task automatic t_map;
    apb(1'h1, {`CCDVP_IDX_GROUP_MAP, 2'h0}, 32'h00e4e4e4);
    group_level <= 4'h5;
    sync_fields();
    chk(upper_vout, 12'h555);
    group_level <= 4'ha;
    repeat (3) @(posedge pclk);
    chk(upper_vout, 12'haaa);
  endtask : t_map
  task automatic t_seq;
    apb(1'h1, {`CCDVP_IDX_BANK_SEQ, 2'h0}, 32'h001f8c41);
    sync_fields();
    chk(vertical_pattern_bank, 20'hf8c41);
    next_line();
    s = sequence_number;
    next_line();
    chk(sequence_number, 5'(s + 5'h1));
    region_sequence <= 5'h13;
    apb(1'h1, {`CCDVP_IDX_BANK_SEQ, 2'h0}, 32'h003f8c41);
    sync_fields();
    next_line();
    chk(sequence_number, 5'h13);
    next_line();
    chk(sequence_number, 5'h13);
  endtask : t_seq
  task automatic t_blank;
    apb(1'h1, {`CCDVP_IDX_BLK_START_END, 2'h0}, 32'h0002800a);
    apb(1'h1, {`CCDVP_IDX_BLK_LEN_REP, 2'h0}, 32'h00a00064);
    sync_fields();
    at_pos(13'h00f, 1'h0);
    chk(horizontal_blanking, 1'h1);
    chk({odd_hclock, even_hclock}, 2'h2);
    chk({last_stage_hclock, third_phase_hclock}, 2'h2);
    at_pos(13'h01e, 1'h0);
    chk(horizontal_blanking, 1'h0);
  endtask : t_blank
  task automatic t_hold;
    apb(1'h1, {`CCDVP_IDX_HOLD_1, 2'h0}, 32'h0005001e);
    apb(1'h1, {`CCDVP_IDX_HOLD_ENABLE, 2'h0}, 32'h00102000);
    sync_fields();
    at_pos(13'h023, 1'h0);
    chk(group_frozen, 4'h1);
    group_level <= 4'hf;
    repeat (2) @(posedge pclk);
    chk(upper_vout, 12'heee);
    at_pos(13'h02d, 1'h0);
    chk(group_frozen, 4'h0);
    chk(upper_vout, 12'hfff);
    at_pos(13'h023, 1'h1);
    chk(group_frozen, 4'h8);
  endtask : t_hold
  task automatic t_timer;
    apb(1'h1, {`CCDVP_IDX_B_START_LEN, 2'h0}, 32'h00008005);
    apb(1'h1, {`CCDVP_IDX_B_REP, 2'h0}, 32'h00000001);
    sync_fields();
    at_pos(13'h009, 1'h0);
    chk(group_active, 4'h2);
    at_pos(13'h00a, 1'h0);
    chk(group_active, 4'h0);
    at_pos(13'h00d, 1'h1);
    chk(group_active, 4'h2);
    at_pos(13'h00e, 1'h1);
    chk(group_active, 4'h0);
  endtask : t_timer
  task automatic t_toggle;
    apb(1'h1, {`CCDVP_IDX_ODD_TOGGLE, 2'h0}, 32'h00058028);
    sync_fields();
    at_pos(13'h02b, 1'h1);
    chk(horizontal_blanking, 1'h1);
    chk({odd_hclock, even_hclock}, 2'h2);
    at_pos(13'h02b, 1'h0);
    chk(horizontal_blanking, 1'h0);
    apb(1'h1, {`CCDVP_IDX_BLK_MODE, 2'h0}, 32'h00000001);
    sync_fields();
    at_pos(13'h02b, 1'h1);
    chk(horizontal_blanking, 1'h0);
  endtask : t_toggle
  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    field_boundary_update = 1'h0;
    three_phase_enable = 1'h1;
    region_sequence = 5'h0;
    group_level = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_refuse();
    t_map();
    t_seq();
    t_blank();
    t_hold();
    t_timer();
    t_toggle();
    report_and_stop();
  end
endmodule : tb_ccd_vertical_pattern_and_hblank_regs
